// File: dbh_pkg.sv
/*
 Package for the DRAM block hit qualifier: register indices, field positions,
 reset values, access-type encoding and carrier structs.
 Assumes a single bus clock domain and the plain register port.
*/
package dbh_pkg;

	localparam int           NUM_BLOCKS    = 2;
	localparam logic [3:0]   ADDR_BLOCK0   = 4'h0;
	localparam logic [3:0]   ADDR_BLOCK1   = 4'h1;
	localparam logic [3:0]   ADDR_BASE0    = 4'h2;
	localparam logic [3:0]   ADDR_BASE1    = 4'h3;
	localparam logic [3:0]   ADDR_IRQSTAT  = 4'h4;
	localparam logic [3:0]   ADDR_IRQMASK  = 4'h5;
	localparam logic [3:0]   ADDR_STATUS   = 4'h6;

	localparam int           BAM_HI        = 31;
	localparam int           BAM_LO        = 18;
	localparam int           WP_BIT        = 8;
	localparam int           AT_HI         = 6;
	localparam int           AT_LO         = 1;
	localparam int           VALID_BIT     = 0;
	localparam logic [31:0]  MASK_WMASK    = 32'hFFFC017F;
	localparam logic [31:0]  BASE_WMASK    = 32'hFFFC0000;
	localparam logic [31:0]  MASK_RESET    = 32'h00000000;
	localparam logic [31:0]  BASE_RESET    = 32'h00000000;

	// Bit positions within the six-bit access-type field (bit 6 down to 1)
	localparam int           AT_CPU        = 5;
	localparam int           AT_ALT        = 4;
	localparam int           AT_SUPC       = 3;
	localparam int           AT_SUPD       = 2;
	localparam int           AT_USRC       = 1;
	localparam int           AT_USRD       = 0;

	localparam int           IRQ_WIDTH     = 3;
	localparam int           IRQ_WPVIOL    = 0;
	localparam int           IRQ_ACCERR    = 1;
	localparam int           IRQ_EXTCYC    = 2;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        write;
		logic        cpuSpace;
		logic        altMaster;
		logic        supervisor;
		logic        code;
	} dbh_req_t;

	typedef struct packed {
		logic [NUM_BLOCKS-1:0] hit;
		logic                  wpBlocked;
		logic                  addrException;
	} dbh_resp_t;

endpackage : dbh_pkg

// File: dbh_hit_decode.sv
/*
 DRAM block hit qualifier: two mask registers plus base registers, per-block
 hit decode, write protection with chip-select fallback and external cycle.
 Assumes requests are single-cycle strobes from the internal bus on clock,
 and chip-select decode and external acknowledge answer as same-clock logic.
*/
`timescale 1ns/1ps

// How it works
// - Two independent mask registers, one per block
// - Address bits 31..18 compared with base
// - Mask zero compares bit, one ignores it
// - Each mask bit acts alone, any pattern
// - Write-protect blocks writes, flags address exception
// - Protected write goes to chip-select decode only when no fallback is busy
// - No chip-select hit launches external cycle
// - Unacknowledged external cycle raises access exception
// - Access-type mask zero allows, one blocks
// - CPU-space mask covers control moves, acknowledges
// - Alternate-master mask covers DMA, external masters
// - Supervisor-code mask covers supervisor fetches
// - Supervisor-data mask covers supervisor data accesses
// - User masks cover user fetches and data
// - Valid bit cleared by reset
// - Valid zero means block decodes nothing
module dbh_hit_decode
	import dbh_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	// Clock, reset, enable
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              clkEn,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [31:0]       regWrData,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic      [31:0]       regRdData,
	// Bus request and answer
	input  wire dbh_req_t          req,
	output dbh_resp_t              resp,
	// Chip-select decode and external bus
	output logic                   csLookup,
	output logic      [31:0]       csAddr,
	input  wire logic              csHit,
	output logic                   extStart,
	input  wire logic              extAck,
	input  wire logic              extDone,
	output logic                   accessException,
	// Interrupt
	output logic                   irq
);

	logic [31:0]          maskReg [NUM_BLOCKS];
	logic [31:0]          baseReg [NUM_BLOCKS];
	logic [IRQ_WIDTH-1:0] irqStat;
	logic [IRQ_WIDTH-1:0] irqMask;
	logic                 csPending;
	logic                 extPending;

	typedef enum {ST_IDLE, ST_CS, ST_EXT} dbh_state_t;
	dbh_state_t state;
	dbh_state_t next_state;

	// Access-type one-hot selection for the current request
	wire logic [5:0] accessSel;
	assign accessSel[AT_CPU]  = req.cpuSpace;
	assign accessSel[AT_ALT]  = ~req.cpuSpace & req.altMaster;
	assign accessSel[AT_SUPC] = ~req.cpuSpace & ~req.altMaster & req.supervisor & req.code;
	assign accessSel[AT_SUPD] = ~req.cpuSpace & ~req.altMaster & req.supervisor & ~req.code;
	assign accessSel[AT_USRC] = ~req.cpuSpace & ~req.altMaster & ~req.supervisor & req.code;
	assign accessSel[AT_USRD] = ~req.cpuSpace & ~req.altMaster & ~req.supervisor & ~req.code;

	wire logic [NUM_BLOCKS-1:0] blockHit;
	wire logic [NUM_BLOCKS-1:0] blockWp;

	genvar b;
	generate
		for (b = 0; b < NUM_BLOCKS; b++) begin : g_block
			wire logic [BAM_HI-BAM_LO:0] diff;
			wire logic [BAM_HI-BAM_LO:0] care;
			wire logic [5:0]             typeMask;
			wire logic                   addrMatch;
			wire logic                   typeOk;
			assign diff      = req.addr[BAM_HI:BAM_LO] ^ baseReg[b][BAM_HI:BAM_LO];
			assign care      = ~maskReg[b][BAM_HI:BAM_LO];
			assign addrMatch = ~|(diff & care);
			assign typeMask  = maskReg[b][AT_HI:AT_LO];
			assign typeOk    = ~|(typeMask & accessSel);
			assign blockHit[b] = req.valid & maskReg[b][VALID_BIT] & addrMatch & typeOk;
			assign blockWp[b]  = maskReg[b][WP_BIT];
		end
	endgenerate

	wire logic wpViolation = req.write & |(blockHit & blockWp);
	wire logic busy        = (state != ST_IDLE);

	// Register decode
	wire logic selMask0 = (regAddr == ADDR_W'(ADDR_BLOCK0));
	wire logic selMask1 = (regAddr == ADDR_W'(ADDR_BLOCK1));
	wire logic selBase0 = (regAddr == ADDR_W'(ADDR_BASE0));
	wire logic selBase1 = (regAddr == ADDR_W'(ADDR_BASE1));
	wire logic selStat  = (regAddr == ADDR_W'(ADDR_IRQSTAT));
	wire logic selIMask = (regAddr == ADDR_W'(ADDR_IRQMASK));
	wire logic selSts   = (regAddr == ADDR_W'(ADDR_STATUS));

	wire logic [31:0] rdMux =
		selMask0 ? maskReg[0] :
		selMask1 ? maskReg[1] :
		selBase0 ? baseReg[0] :
		selBase1 ? baseReg[1] :
		selStat  ? {{(32-IRQ_WIDTH){1'b0}}, irqStat} :
		selIMask ? {{(32-IRQ_WIDTH){1'b0}}, irqMask} :
		selSts   ? {29'h0, extPending, csPending, busy} :
		32'h00000000;

	// Sticky events; a set in the clearing cycle survives
	wire logic [IRQ_WIDTH-1:0] irqEvent;
	wire logic                 extFail = (state == ST_EXT) & extDone & ~extAck;
	assign irqEvent[IRQ_WPVIOL] = wpViolation & ~busy;
	assign irqEvent[IRQ_ACCERR] = extFail;
	assign irqEvent[IRQ_EXTCYC] = (state == ST_CS) & ~csHit;
	wire logic [IRQ_WIDTH-1:0] statClr = (regWrite & selStat) ? regWrData[IRQ_WIDTH-1:0] : '0;
	wire logic [IRQ_WIDTH-1:0] next_irqStat = (irqStat & ~statClr) | irqEvent;

	// Protected-write fallback sequence
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (wpViolation) next_state = ST_CS;
			ST_CS:   next_state = csHit ? ST_IDLE : ST_EXT;
			ST_EXT:  if (extDone) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// Register file; reserved bits kept zero whatever software writes
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			maskReg[0] <= MASK_RESET;
			maskReg[1] <= MASK_RESET;
			baseReg[0] <= BASE_RESET;
			baseReg[1] <= BASE_RESET;
			irqMask    <= '0;
			irqStat    <= '0;
			regRdData  <= '0;
		end else if (clkEn) begin
			if (regWrite & selMask0) maskReg[0] <= regWrData & MASK_WMASK;
			if (regWrite & selMask1) maskReg[1] <= regWrData & MASK_WMASK;
			if (regWrite & selBase0) baseReg[0] <= regWrData & BASE_WMASK;
			if (regWrite & selBase1) baseReg[1] <= regWrData & BASE_WMASK;
			if (regWrite & selIMask) irqMask <= regWrData[IRQ_WIDTH-1:0];
			irqStat   <= next_irqStat;
			regRdData <= regRead ? rdMux : 32'h00000000;
		end
	end

	// Fallback state and outputs, all registered
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state           <= ST_IDLE;
			resp            <= '0;
			csLookup        <= 1'b0;
			csAddr          <= '0;
			csPending       <= 1'b0;
			extPending      <= 1'b0;
			extStart        <= 1'b0;
			accessException <= 1'b0;
			irq             <= 1'b0;
		end else if (clkEn) begin
			state    <= next_state;
			// Protected write never reaches DRAM
			resp.hit           <= wpViolation ? '0 : blockHit;
			resp.wpBlocked     <= wpViolation;
			resp.addrException <= wpViolation;
			csLookup   <= (state == ST_IDLE) & wpViolation;
			csAddr     <= (state == ST_IDLE && wpViolation) ? req.addr : csAddr;
			csPending  <= next_state == ST_CS;
			extPending <= next_state == ST_EXT;
			extStart   <= (state == ST_CS) & ~csHit;
			accessException <= extFail;
			irq <= |(next_irqStat & irqMask);
		end
	end

endmodule : dbh_hit_decode

// File: dbh_checker.sv
/* Checker for the block hit qualifier ports.
 Assumes it is bound into dbh_hit_decode and one clock domain. */
`timescale 1ns/1ps
module dbh_checker
	import dbh_pkg::*;
(
	// Clock, reset, register read
	input wire logic        clock, rst_n, regRead,
	input wire logic [31:0] regRdData, csAddr,
	// Request and far side
	input wire dbh_req_t    req,
	input wire dbh_resp_t   resp,
	input wire logic        csLookup, csHit, extStart, extAck, extDone, accessException
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_read_slot: assert property (regRdData != 0 |-> $past(regRead))
		else $error("read data outside slot");
	chk_hit_cause: assert property (resp.hit != 0 |-> $past(req.valid))
		else $error("hit without request");
	chk_wp_refuse: assert property (resp.addrException |-> resp.hit == 0 && resp.wpBlocked)
		else $error("protected write hit");
	chk_wp_write: assert property (resp.wpBlocked |-> $past(req.write))
		else $error("read refused");
	chk_lookup_addr: assert property (csLookup |-> resp.addrException &&
		csAddr == $past(req.addr)) else $error("bad lookup");
	chk_ext_miss: assert property (csLookup && !csHit |=> extStart)
		else $error("no external cycle");
	chk_ext_hit: assert property (csLookup && csHit |=> !extStart)
		else $error("needless external cycle");
	chk_acc_exc: assert property (accessException |-> $past(extDone && !extAck))
		else $error("bad access exception");
	cover property (resp.hit[0]);
	cover property (csLookup && csHit);
	cover property (accessException);
endmodule : dbh_checker
bind dbh_hit_decode dbh_checker dbh_checker_i (.*);

// File: dbh_far_side.sv
/* Far side: chip-select decode and external responder.
 Assumes the bench sets csAnswer and ackAnswer between edges. */
`timescale 1ns/1ps
module dbh_far_side (
	// Bench controls
	input wire logic clock, csAnswer, ackAnswer,
	// Design side
	input wire logic csLookup, extStart,
	output logic     csHit, extAck, extDone
);
	logic [1:0] waitCnt = 2'h0;
	logic       flip = 1'b0;
	// Slow answer: the external cycle ends three cycles after launch
	always @(posedge clock) begin
		flip <= !flip;
		waitCnt <= extStart ? 2'h3 : waitCnt - {1'b0, waitCnt != 2'h0};
	end
	assign extDone = waitCnt == 2'h1;
	// Outside their slots answers toggle, never a stale value
	assign csHit = csLookup ? csAnswer : flip;
	assign extAck = extDone ? ackAnswer : flip;
endmodule : dbh_far_side

// File: dbh_hit_decode_tb_top.sv
/* Bench for dbh_hit_decode: registers, hit decode, protected writes, irq.
 Assumes the far-side model, 20 MHz clock, synchronous reset. */
`timescale 1ns/1ps
module dbh_hit_decode_tb_top
	import dbh_pkg::*;
;
	logic        clock = 0, rst_n = 0, clkEn = 1, regWrite = 0, regRead = 0;
	logic        csAnswer = 0, ackAnswer = 0, seen, csLookup, csHit, extStart;
	logic        extAck, extDone, accessException, irq;
	logic [3:0]  regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0, regRdData, csAddr, d;
	dbh_req_t    req = '0;
	dbh_resp_t   resp, o;
	int          n_fail = 0, n_tests = 0, cycles = 0;
	always #25 clock = !clock;
	dbh_hit_decode dbh_hit_decode_i (.*);
	dbh_far_side dbh_far_side_i (.*);
	task automatic check(input string what, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Write when w, else read into d
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge clock);
		{regWrite, regRead, regAddr, regWrData} <= {w, !w, a, v};
		@(posedge clock);
		{regWrite, regRead} <= 2'b00;
		#1 d = regRdData;
	endtask : bus
	// Response lands in o; n idle cycles gather exceptions
	task automatic send(input dbh_req_t r, input int n);
		@(posedge clock);
		req <= r;
		@(posedge clock);
		req.valid <= 1'b0;
		#1 o = resp;
		seen = 1'b0;
		repeat (n) @(posedge clock) #1 seen |= accessException;
	endtask : send
	function automatic dbh_req_t mk(input logic [31:0] a, input logic w, input int k);
		return '{1'b1, a, w, k == AT_CPU, k == AT_ALT, k inside {AT_SUPC, AT_SUPD},
			k inside {AT_SUPC, AT_USRC}};
	endfunction : mk
	task automatic t_regs;
		bus(1'b0, ADDR_BLOCK0, 32'h0);
		check("mask0 reset", MASK_RESET, d);
		bus(1'b1, 4'hF, 32'hFFFFFFFF);
		bus(1'b0, 4'hF, 32'h0);
		check("unmapped", 32'h0, d);
		bus(1'b1, ADDR_BLOCK1, 32'hFFFFFFFF);
		bus(1'b0, ADDR_BLOCK1, 32'h0);
		check("mask1", MASK_WMASK, d);
	endtask : t_regs
	task automatic t_hit;
		bus(1'b1, ADDR_BASE0, 32'h10000000);
		send(mk(32'h10000000, 1'b0, AT_USRD), 0);
		check("invalid", 32'h0, o.hit);
		bus(1'b1, ADDR_BLOCK0, 32'h80100001);
		send(mk(32'h90100000, 1'b0, AT_USRD), 0);
		check("masked", 32'h1, o.hit);
		send(mk(32'h10080000, 1'b0, AT_USRD), 0);
		check("bit 19", 32'h0, o.hit);
		for (int k = 0; k < 6; k++) begin
			bus(1'b1, ADDR_BLOCK0, 32'h80100001 | (32'h2 << k));
			send(mk(32'h10000000, 1'b1, k), 0);
			check("blocked", 32'h0, o.hit);
			send(mk(32'h10000000, 1'b1, (k + 1) % 6), 0);
			check("allowed", 32'h1, o.hit);
		end
	endtask : t_hit
	task automatic t_wp;
		bus(1'b1, ADDR_IRQMASK, 32'h2);
		bus(1'b1, ADDR_BASE1, 32'h20000000);
		bus(1'b1, ADDR_BLOCK1, 32'h00000101);
		send(mk(32'h20000040, 1'b0, AT_SUPD), 0);
		check("read", 32'h2, o.hit);
		csAnswer = 1'b1;
		send(mk(32'h20000040, 1'b1, AT_SUPD), 12);
		check("refuse", 32'h3, o);
		check("cs hit", 32'h0, seen);
		{csAnswer, ackAnswer} = 2'b01;
		send(mk(32'h20000044, 1'b1, AT_SUPD), 12);
		check("acked", 32'h0, seen);
		ackAnswer = 1'b0;
		send(mk(32'h20000048, 1'b1, AT_SUPD), 12);
		check("no ack", 32'h1, seen);
		check("cs addr", 32'h20000048, csAddr);
		bus(1'b0, ADDR_IRQSTAT, 32'h0);
		check("events", 32'h7, d);
		check("irq on", 32'h1, irq);
		bus(1'b1, ADDR_IRQMASK, 32'h0);
		bus(1'b1, ADDR_IRQSTAT, 32'h7);
		check("irq masked", 32'h0, irq);
		bus(1'b0, ADDR_IRQSTAT, 32'h0);
		check("cleared", 32'h0, d);
	endtask : t_wp
	// Write under a low enable must not land
	task automatic t_freeze;
		clkEn <= 1'b0;
		bus(1'b1, ADDR_IRQMASK, 32'h5);
		clkEn <= 1'b1;
		bus(1'b0, ADDR_IRQMASK, 32'h0);
		check("frozen mask", 32'h0, d);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("idle status", 32'h0, d);
	endtask : t_freeze
	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	// Far above the roughly 125 cycles needed
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_hit();
		t_wp();
		t_freeze();
		wrap_up();
	end
endmodule : dbh_hit_decode_tb_top
